// ===== rtl/cpucrf_regs.svh
`ifndef CPUCRF_REGS_SVH
`define CPUCRF_REGS_SVH

// Register selector codes on the access port
`define CPUCRF_SEL_PSW 4'h0
`define CPUCRF_SEL_CFB 4'h1
`define CPUCRF_SEL_CACHE_CTL 4'h2
`define CPUCRF_SEL_CACHE_ADDR 4'h3
`define CPUCRF_SEL_EXC_BASE 4'h4
`define CPUCRF_SEL_SRC_SPACE 4'h5
`define CPUCRF_SEL_DST_SPACE 4'h6
`define CPUCRF_SEL_USER_ROOT 4'h7
`define CPUCRF_SEL_SUP_ROOT 4'h8
`define CPUCRF_SEL_XLAT_CTL 4'h9
`define CPUCRF_SEL_WINDOW0 4'hA
`define CPUCRF_SEL_WINDOW1 4'hB
`define CPUCRF_SEL_XLAT_STAT 4'hC

// Defined bits of the status word (12 of 16)
`define CPUCRF_PSW_MASK 16'hF71F
`define CPUCRF_CFB_MASK 16'h001F
`define CPUCRF_SPACE_MASK 32'h0000_0007

// Reset values
`define CPUCRF_PSW_RESET 16'h2700
`define CPUCRF_RESET32 32'h0000_0000
`define CPUCRF_RESET64 64'h0000_0000_0000_0000

// Index extension word fields
`define CPUCRF_IDX_DA 15
`define CPUCRF_IDX_SIZE 11

`endif

// ===== rtl/cpucrf_pkg.sv
package cpucrf_pkg;

	typedef logic [3:0] cpucrf_sel_t;

	typedef enum logic [1:0] {
		CPUCRF_BYTE,
		CPUCRF_WORD,
		CPUCRF_LONG,
		CPUCRF_QUAD
	} cpucrf_size_e;

	typedef enum logic [1:0] {
		CPUCRF_ALT_MOVE,
		CPUCRF_ALT_PRELOAD,
		CPUCRF_ALT_FLUSH,
		CPUCRF_ALT_PROBE
	} cpucrf_alt_e;

endpackage

// ===== rtl/cpucrf.sv
`timescale 1ns/1ps
`include "cpucrf_regs.svh"

module cpucrf (
	input wire logic clk,
	input wire logic resetn,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire cpucrf_pkg::cpucrf_sel_t acc_sel,
	input wire cpucrf_pkg::cpucrf_size_e acc_size,
	input wire logic acc_super,
	input wire logic [63:0] acc_wdata,
	output logic [63:0] acc_rdata,
	output logic acc_done,
	output logic acc_priv_fault,
	output logic acc_size_fault,
	output logic [15:0] status_word,
	output logic [31:0] cache_ctl,
	output logic [31:0] exc_base,
	output logic [63:0] user_root,
	output logic [63:0] sup_root,
	output logic [31:0] xlat_ctl,
	output logic [31:0] window0,
	output logic [31:0] window1,
	input wire cpucrf_pkg::cpucrf_alt_e alt_kind,
	input wire logic alt_is_write,
	output logic [2:0] alt_fc,
	input wire logic probe_done,
	input wire logic [15:0] probe_status,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_bytes,
	output logic [31:0] mem_low_word_addr,
	output logic [31:0] mem_last_addr,
	input wire logic [31:0] fetch_addr,
	output logic fetch_misaligned,
	input wire logic [2:0] bit_num,
	output logic [7:0] bit_mask,
	input wire logic [31:0] bf_base,
	input wire logic [31:0] bf_offset,
	input wire logic [4:0] bf_width,
	output logic [31:0] bf_byte_addr,
	output logic [2:0] bf_first_bit,
	output logic [2:0] bf_byte_count,
	input wire logic [15:0] op_word,
	input wire logic [15:0] ext_word,
	input wire logic [31:0] idx_value,
	input wire cpucrf_pkg::cpucrf_size_e imm_size,
	output logic [2:0] ea_mode,
	output logic [2:0] ea_reg,
	output logic [2:0] ea_ext_words,
	output logic idx_is_addr,
	output logic [2:0] idx_regnum,
	output logic [31:0] idx_scaled
);

	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_n;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_n = rst_sync_q;

	// Transfer size each register demands
	function automatic cpucrf_pkg::cpucrf_size_e need_size(input cpucrf_pkg::cpucrf_sel_t s);
		case (s)
			`CPUCRF_SEL_PSW, `CPUCRF_SEL_CFB: need_size = cpucrf_pkg::CPUCRF_WORD;
			`CPUCRF_SEL_XLAT_STAT: need_size = cpucrf_pkg::CPUCRF_WORD;
			`CPUCRF_SEL_USER_ROOT, `CPUCRF_SEL_SUP_ROOT: need_size = cpucrf_pkg::CPUCRF_QUAD;
			default: need_size = cpucrf_pkg::CPUCRF_LONG;
		endcase
	endfunction

	// Extension words needed for an EA field
	function automatic logic [2:0] ext_count(input logic [2:0] m, input logic [2:0] r,
			input cpucrf_pkg::cpucrf_size_e sz);
		logic [2:0] n;
		n = 3'h0;
		case (m)
			3'h5, 3'h6: n = 3'h1;
			3'h7: begin
				case (r)
					3'h0, 3'h2, 3'h3: n = 3'h1;
					3'h1: n = 3'h2;
					3'h4: n = (sz == cpucrf_pkg::CPUCRF_QUAD) ? 3'h4 :
						(sz == cpucrf_pkg::CPUCRF_LONG) ? 3'h2 : 3'h1;
					default: n = 3'h0;
				endcase
			end
			default: n = 3'h0;
		endcase
		ext_count = n;
	endfunction

	logic [15:0] psw_q;
	logic [31:0] cache_ctl_q;
	logic [31:0] cache_addr_q;
	logic [31:0] exc_base_q;
	logic [2:0] src_space_q;
	logic [2:0] dst_space_q;
	logic [63:0] user_root_q;
	logic [63:0] sup_root_q;
	logic [31:0] xlat_ctl_q;
	logic [31:0] window0_q;
	logic [31:0] window1_q;
	logic [15:0] xlat_stat_q;

	logic [63:0] rdata_q;
	logic done_q;
	logic priv_q;
	logic size_q;

	logic [31:0] mem_low_q;
	logic [31:0] mem_last_q;
	logic fetch_mis_q;
	logic [7:0] bit_mask_q;
	logic [31:0] bf_addr_q;
	logic [2:0] bf_bit_q;
	logic [2:0] bf_cnt_q;
	logic [2:0] ea_mode_q;
	logic [2:0] ea_reg_q;
	logic [2:0] ea_ext_q;
	logic idx_addr_q;
	logic [2:0] idx_reg_q;
	logic [31:0] idx_scaled_q;

	wire sel_user_ok = (acc_sel == `CPUCRF_SEL_CFB);
	wire sel_known = (acc_sel <= `CPUCRF_SEL_XLAT_STAT);
	wire priv_bad = acc_req & ~acc_super & ~sel_user_ok;
	wire size_bad = acc_req & ~priv_bad & (~sel_known | (acc_size != need_size(acc_sel)));
	wire acc_ok = acc_req & ~priv_bad & ~size_bad;
	wire wr_ok = acc_ok & acc_write;

	wire wr_psw = wr_ok & (acc_sel == `CPUCRF_SEL_PSW);
	wire wr_cfb = wr_ok & (acc_sel == `CPUCRF_SEL_CFB);
	wire wr_cctl = wr_ok & (acc_sel == `CPUCRF_SEL_CACHE_CTL);
	wire wr_caddr = wr_ok & (acc_sel == `CPUCRF_SEL_CACHE_ADDR);
	wire wr_ebase = wr_ok & (acc_sel == `CPUCRF_SEL_EXC_BASE);
	wire wr_sspc = wr_ok & (acc_sel == `CPUCRF_SEL_SRC_SPACE);
	wire wr_dspc = wr_ok & (acc_sel == `CPUCRF_SEL_DST_SPACE);
	wire wr_uroot = wr_ok & (acc_sel == `CPUCRF_SEL_USER_ROOT);
	wire wr_sroot = wr_ok & (acc_sel == `CPUCRF_SEL_SUP_ROOT);
	wire wr_xctl = wr_ok & (acc_sel == `CPUCRF_SEL_XLAT_CTL);
	wire wr_win0 = wr_ok & (acc_sel == `CPUCRF_SEL_WINDOW0);
	wire wr_win1 = wr_ok & (acc_sel == `CPUCRF_SEL_WINDOW1);
	wire wr_xstat = wr_ok & (acc_sel == `CPUCRF_SEL_XLAT_STAT);

	// Reserved bits are never stored, so they always read zero
	wire [15:0] psw_d_full = acc_wdata[15:0] & `CPUCRF_PSW_MASK;
	// Condition byte write keeps the upper byte whatever the privilege
	wire [15:0] psw_d_cfb = (psw_q & ~`CPUCRF_CFB_MASK) |
		(acc_wdata[15:0] & `CPUCRF_CFB_MASK);
	wire [15:0] psw_d = wr_psw ? psw_d_full : (wr_cfb ? psw_d_cfb : psw_q);

	// A probe finishing in the same cycle as a software write wins
	wire [15:0] xstat_d = probe_done ? probe_status :
		(wr_xstat ? acc_wdata[15:0] : xlat_stat_q);

	wire [63:0] rd_mux =
		(acc_sel == `CPUCRF_SEL_PSW) ? {48'h0, psw_q} :
		(acc_sel == `CPUCRF_SEL_CFB) ? {48'h0, psw_q & `CPUCRF_CFB_MASK} :
		(acc_sel == `CPUCRF_SEL_CACHE_CTL) ? {32'h0, cache_ctl_q} :
		(acc_sel == `CPUCRF_SEL_CACHE_ADDR) ? {32'h0, cache_addr_q} :
		(acc_sel == `CPUCRF_SEL_EXC_BASE) ? {32'h0, exc_base_q} :
		(acc_sel == `CPUCRF_SEL_SRC_SPACE) ? {61'h0, src_space_q} :
		(acc_sel == `CPUCRF_SEL_DST_SPACE) ? {61'h0, dst_space_q} :
		(acc_sel == `CPUCRF_SEL_USER_ROOT) ? user_root_q :
		(acc_sel == `CPUCRF_SEL_SUP_ROOT) ? sup_root_q :
		(acc_sel == `CPUCRF_SEL_XLAT_CTL) ? {32'h0, xlat_ctl_q} :
		(acc_sel == `CPUCRF_SEL_WINDOW0) ? {32'h0, window0_q} :
		(acc_sel == `CPUCRF_SEL_WINDOW1) ? {32'h0, window1_q} :
		{48'h0, xlat_stat_q};
	wire [63:0] rdata_d = (acc_ok & ~acc_write) ? rd_mux : 64'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			psw_q <= `CPUCRF_PSW_RESET;
			xlat_stat_q <= 16'h0000;
		end else begin
			psw_q <= psw_d;
			xlat_stat_q <= xstat_d;
		end
	end

	// Faulted writes leave every register untouched
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cache_ctl_q <= `CPUCRF_RESET32;
			cache_addr_q <= `CPUCRF_RESET32;
			exc_base_q <= `CPUCRF_RESET32;
		end else begin
			if (wr_cctl) cache_ctl_q <= acc_wdata[31:0];
			if (wr_caddr) cache_addr_q <= acc_wdata[31:0];
			if (wr_ebase) exc_base_q <= acc_wdata[31:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_space_q <= 3'h0;
			dst_space_q <= 3'h0;
		end else begin
			if (wr_sspc) src_space_q <= acc_wdata[2:0];
			if (wr_dspc) dst_space_q <= acc_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			user_root_q <= `CPUCRF_RESET64;
			sup_root_q <= `CPUCRF_RESET64;
			xlat_ctl_q <= `CPUCRF_RESET32;
			window0_q <= `CPUCRF_RESET32;
			window1_q <= `CPUCRF_RESET32;
		end else begin
			if (wr_uroot) user_root_q <= acc_wdata;
			if (wr_sroot) sup_root_q <= acc_wdata;
			if (wr_xctl) xlat_ctl_q <= acc_wdata[31:0];
			if (wr_win0) window0_q <= acc_wdata[31:0];
			if (wr_win1) window1_q <= acc_wdata[31:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 64'h0;
			done_q <= 1'b0;
			priv_q <= 1'b0;
			size_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			done_q <= acc_req;
			priv_q <= priv_bad;
			size_q <= size_bad;
		end
	end

	assign acc_rdata = rdata_q;
	assign acc_done = done_q;
	assign acc_priv_fault = priv_q;
	assign acc_size_fault = size_q;
	assign status_word = psw_q;
	assign cache_ctl = cache_ctl_q;
	assign exc_base = exc_base_q;
	assign user_root = user_root_q;
	assign sup_root = sup_root_q;
	assign xlat_ctl = xlat_ctl_q;
	assign window0 = window0_q;
	assign window1 = window1_q;

	// Probe always reads its space from the source code register
	wire use_dst = alt_is_write & (alt_kind != cpucrf_pkg::CPUCRF_ALT_PROBE);
	assign alt_fc = use_dst ? dst_space_q : src_space_q;

	// Operand byte addresses, most significant byte first
	wire [7:0] mem_len = (mem_bytes == 8'h00) ? 8'h01 : mem_bytes;
	wire [31:0] mem_low_d = mem_addr + 32'h0000_0002;
	wire [31:0] mem_last_d = mem_addr + {24'h0, mem_len} - 32'h0000_0001;
	wire fetch_mis_d = fetch_addr[0];

	// Bit number counts up from the LSB, so 7 selects the MSB
	wire [7:0] bit_mask_d = 8'h01 << bit_num;

	// Signed offset: bytes by arithmetic shift, bit from the MSB
	wire [31:0] bf_off_bytes = $signed(bf_offset) >>> 3;
	wire [31:0] bf_addr_d = bf_base + bf_off_bytes;
	wire [2:0] bf_bit_d = bf_offset[2:0];
	// Width code zero stands for 32 bits
	wire [5:0] bf_w = (bf_width == 5'h00) ? 6'h20 : {1'b0, bf_width};
	wire [6:0] bf_span = {4'h0, bf_bit_d} + {1'b0, bf_w} + 7'h07;
	wire [2:0] bf_cnt_d = bf_span[5:3];

	wire [2:0] mode_d = op_word[5:3];
	wire [2:0] reg_d = op_word[2:0];
	wire [2:0] ext_d = ext_count(mode_d, reg_d, imm_size);

	// Word index is sign-extended before scaling
	wire [31:0] idx_raw = ext_word[`CPUCRF_IDX_SIZE] ? idx_value :
		{{16{idx_value[15]}}, idx_value[15:0]};
	wire [31:0] idx_scaled_d = idx_raw << ext_word[10:9];
	wire idx_addr_d = ext_word[`CPUCRF_IDX_DA];
	wire [2:0] idx_reg_d = ext_word[14:12];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_low_q <= 32'h0;
			mem_last_q <= 32'h0;
			fetch_mis_q <= 1'b0;
			bit_mask_q <= 8'h01;
		end else begin
			mem_low_q <= mem_low_d;
			mem_last_q <= mem_last_d;
			fetch_mis_q <= fetch_mis_d;
			bit_mask_q <= bit_mask_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bf_addr_q <= 32'h0;
			bf_bit_q <= 3'h0;
			bf_cnt_q <= 3'h1;
		end else begin
			bf_addr_q <= bf_addr_d;
			bf_bit_q <= bf_bit_d;
			bf_cnt_q <= bf_cnt_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ea_mode_q <= 3'h0;
			ea_reg_q <= 3'h0;
			ea_ext_q <= 3'h0;
		end else begin
			ea_mode_q <= mode_d;
			ea_reg_q <= reg_d;
			ea_ext_q <= ext_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_addr_q <= 1'b0;
			idx_reg_q <= 3'h0;
			idx_scaled_q <= 32'h0;
		end else begin
			idx_addr_q <= idx_addr_d;
			idx_reg_q <= idx_reg_d;
			idx_scaled_q <= idx_scaled_d;
		end
	end

	assign mem_low_word_addr = mem_low_q;
	assign mem_last_addr = mem_last_q;
	assign fetch_misaligned = fetch_mis_q;
	assign bit_mask = bit_mask_q;
	assign bf_byte_addr = bf_addr_q;
	assign bf_first_bit = bf_bit_q;
	assign bf_byte_count = bf_cnt_q;
	assign ea_mode = ea_mode_q;
	assign ea_reg = ea_reg_q;
	assign ea_ext_words = ea_ext_q;
	assign idx_is_addr = idx_addr_q;
	assign idx_regnum = idx_reg_q;
	assign idx_scaled = idx_scaled_q;

endmodule

// ===== test/cpucrf_monitor.sv
`timescale 1ns/1ps
module cpucrf_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire cpucrf_pkg::cpucrf_sel_t acc_sel,
	input wire cpucrf_pkg::cpucrf_size_e acc_size,
	input wire logic acc_super,
	input wire logic acc_done,
	input wire logic acc_priv_fault,
	input wire logic acc_size_fault,
	input wire logic [15:0] status_word,
	input wire logic [31:0] cache_ctl,
	input wire logic [2:0] bit_num,
	input wire logic [7:0] bit_mask,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_low_word_addr
);
	// Internal reset lags resetn by two edges, so checks wait a little longer
	logic [1:0] up_q;
	wire up = up_q == 2'h3;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) up_q <= 2'h0;
		else if (!up) up_q <= up_q + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	reserved_zero_a: assert property ((status_word & 16'h08E0) == 16'h0000)
		else $error("reserved status bit set");
	user_priv_a: assert property (up && acc_req && !acc_super && acc_sel != 4'h1
		|=> acc_done && acc_priv_fault) else $error("privilege fault missing");
	flag_byte_a: assert property (up && acc_req && acc_sel == 4'h1 && acc_size == cpucrf_pkg::CPUCRF_WORD
		|=> acc_done && !acc_priv_fault && !acc_size_fault) else $error("condition byte refused");
	status_word_a: assert property (up && acc_req && acc_super && acc_sel == 4'h0
		&& acc_size != cpucrf_pkg::CPUCRF_WORD |=> acc_size_fault) else $error("status size not refused");
	long_only_a: assert property (up && acc_req && acc_super && acc_sel inside {4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB}
		&& acc_size != cpucrf_pkg::CPUCRF_LONG |=> acc_size_fault) else $error("long size not refused");
	quad_only_a: assert property (up && acc_req && acc_super && acc_sel inside {4'h7, 4'h8}
		&& acc_size != cpucrf_pkg::CPUCRF_QUAD |=> acc_size_fault) else $error("quad size not refused");
	denied_hold_a: assert property (up && acc_req && acc_write && !acc_super && acc_sel == 4'h2
		|=> $stable(cache_ctl)) else $error("denied write changed register");
	bit_msb_a: assert property (up |=> bit_mask == 8'h01 << $past(bit_num))
		else $error("bit mask wrong");
	low_word_a: assert property (up |=> mem_low_word_addr == $past(mem_addr) + 32'h2)
		else $error("low word address wrong");
endmodule
bind cpucrf cpucrf_monitor u_mon (.clk, .resetn, .acc_req, .acc_write, .acc_sel, .acc_size, .acc_super,
	.acc_done, .acc_priv_fault, .acc_size_fault, .status_word, .cache_ctl, .bit_num, .bit_mask, .mem_addr,
	.mem_low_word_addr);

// ===== test/cpu_control_register_file_tb_top.sv
`timescale 1ns/1ps
module cpu_control_register_file_tb_top;
	localparam cpucrf_pkg::cpucrf_size_e SZW = cpucrf_pkg::CPUCRF_WORD;
	localparam cpucrf_pkg::cpucrf_size_e SZL = cpucrf_pkg::CPUCRF_LONG;
	localparam cpucrf_pkg::cpucrf_size_e SZQ = cpucrf_pkg::CPUCRF_QUAD;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic acc_req, acc_write, acc_super, alt_is_write, probe_done;
	cpucrf_pkg::cpucrf_sel_t acc_sel;
	cpucrf_pkg::cpucrf_size_e acc_size, imm_size;
	cpucrf_pkg::cpucrf_alt_e alt_kind;
	logic [63:0] acc_wdata, acc_rdata, user_root, sup_root;
	logic [31:0] cache_ctl, exc_base, xlat_ctl, window0, window1, mem_addr, mem_low_word_addr, mem_last_addr;
	logic [31:0] fetch_addr, bf_base, bf_offset, bf_byte_addr, idx_value, idx_scaled;
	logic [15:0] status_word, probe_status, op_word, ext_word;
	logic [7:0] mem_bytes, bit_mask;
	logic [4:0] bf_width;
	logic [2:0] alt_fc, bit_num, bf_first_bit, bf_byte_count, ea_mode, ea_reg, ea_ext_words, idx_regnum;
	logic acc_done, acc_priv_fault, acc_size_fault, fetch_misaligned, idx_is_addr;
	int n_mismatch = 0;
	int total_checks = 0;
	cpucrf DUT (.*);
	always #25 clk = ~clk;
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One access per call; answer is looked at in its single cycle
	task automatic acc(input logic wr, input logic sup, input cpucrf_pkg::cpucrf_sel_t sel,
		input cpucrf_pkg::cpucrf_size_e sz, input logic [63:0] wd, input logic [63:0] exp, input logic [1:0] flt);
		{acc_req, acc_write, acc_super, acc_sel, acc_wdata} = {1'b1, wr, sup, sel, wd};
		acc_size = sz;
		@(negedge clk);
		chk("done", acc_done, 64'h1);
		chk("faults", {acc_priv_fault, acc_size_fault}, flt);
		chk("rdata", acc_rdata, exp);
	endtask
	task automatic idle;
		acc_req = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_status;
		acc(1, 1, 4'h0, SZW, 64'hFFFF, 0, 0);
		acc(0, 1, 4'h0, SZW, 0, 64'hF71F, 0);
		acc(1, 1, 4'h0, SZL, 0, 0, 2'h1);
		acc(1, 0, 4'h1, SZW, 64'hFFE0, 0, 0);
		acc(0, 0, 4'h1, SZW, 0, 0, 0);
		acc(1, 0, 4'h1, SZL, 0, 0, 2'h1);
		chk("status", status_word, 16'hF700);
	endtask
	task automatic t_long;
		cpucrf_pkg::cpucrf_sel_t s[6] = '{4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB};
		foreach (s[i]) begin
			acc(1, 1, s[i], SZL, {32'hFFFF_FFFF, 28'hA5A_55A5, s[i]}, 0, 0);
			acc(1, 1, s[i], SZW, 0, 0, 2'h1);
			acc(0, 1, s[i], SZL, 0, {32'h0, 28'hA5A_55A5, s[i]}, 0);
		end
		chk("window", {window0, window1}, 64'hA5A5_5A5A_A5A5_5A5B);
		chk("xlat_exc", {xlat_ctl, exc_base}, 64'hA5A5_5A59_A5A5_5A54);
	endtask
	task automatic t_space;
		acc(1, 1, 4'h5, SZL, 64'hFFFF_FFFF_FFFF_FFFF, 0, 0);
		acc(1, 1, 4'h6, SZL, 64'hD, 0, 0);
		acc(0, 1, 4'h5, SZL, 0, 64'h7, 0);
		acc(0, 1, 4'h6, SZL, 0, 64'h5, 0);
		idle;
		for (int k = 0; k < 4; k++) begin
			alt_kind = cpucrf_pkg::cpucrf_alt_e'(k);
			alt_is_write = 1'b1;
			@(negedge clk);
			chk("alt_fc_wr", alt_fc, (k == 3) ? 64'h7 : 64'h5);
			alt_is_write = 1'b0;
			@(negedge clk);
			chk("alt_fc_rd", alt_fc, 64'h7);
		end
	endtask
	task automatic t_root;
		acc(1, 1, 4'h7, SZQ, 64'h0123_4567_89AB_CDEF, 0, 0);
		acc(1, 1, 4'h8, SZQ, 64'hFEDC_BA98_7654_3210, 0, 0);
		acc(1, 1, 4'h7, SZL, 0, 0, 2'h1);
		acc(0, 1, 4'h8, SZQ, 0, 64'hFEDC_BA98_7654_3210, 0);
		chk("user_root", user_root, 64'h0123_4567_89AB_CDEF);
		chk("sup_root", sup_root, 64'hFEDC_BA98_7654_3210);
	endtask
	task automatic t_priv;
		acc(1, 0, 4'h2, SZL, 64'h1, 0, 2'h2);
		acc(0, 0, 4'hC, SZW, 0, 0, 2'h2);
		acc(0, 1, 4'hD, SZL, 0, 0, 2'h1);
		chk("cache_ctl", cache_ctl, 32'hA5A5_5A52);
	endtask
	task automatic t_probe;
		idle;
		{probe_done, probe_status} = {1'b1, 16'hBEEF};
		@(negedge clk);
		probe_done = 1'b0;
		acc(0, 1, 4'hC, SZW, 0, 64'hBEEF, 0);
		acc(1, 1, 4'hC, SZW, 64'h1234, 0, 0);
		acc(0, 1, 4'hC, SZW, 0, 64'h1234, 0);
		{probe_done, probe_status} = {1'b1, 16'hCAFE};
		acc(1, 1, 4'hC, SZW, 64'h5678, 0, 0);
		probe_done = 1'b0;
		acc(0, 1, 4'hC, SZW, 0, 64'hCAFE, 0);
		idle;
	endtask
	task automatic t_help;
		{mem_addr, mem_bytes, fetch_addr, bit_num} = {32'h1000, 8'hFF, 32'h1001, 3'h7};
		{bf_base, bf_offset, bf_width} = {32'h100, 32'hFFFF_FFFF, 5'h1};
		{op_word, ext_word, idx_value} = {16'h0030, 16'h9A00, 32'h10};
		@(negedge clk);
		chk("mem", {mem_low_word_addr, mem_last_addr}, 64'h1002_0000_10FE);
		chk("fetch", fetch_misaligned, 64'h1);
		chk("bit_mask", bit_mask, 64'h80);
		chk("bf", {bf_byte_addr, bf_first_bit, bf_byte_count}, {32'hFF, 3'h7, 3'h1});
		chk("ea", {ea_mode, ea_reg, ea_ext_words}, {3'h6, 3'h0, 3'h1});
		chk("idx", {idx_is_addr, idx_regnum, idx_scaled}, {1'b1, 3'h1, 32'h20});
		{bf_offset, bf_width, op_word, ext_word, idx_value} = {32'h5, 5'h0, 16'h003C, 16'h0600, 32'hFFFF};
		@(negedge clk);
		chk("bf32", {bf_byte_addr, bf_first_bit, bf_byte_count}, {32'h100, 3'h5, 3'h5});
		chk("imm", ea_ext_words, 64'h2);
		chk("idx_w", idx_scaled, 64'hFFFF_FFF8);
		op_word = 16'h0039;
		mem_bytes = 8'h00;
		@(negedge clk);
		chk("abs_long", ea_ext_words, 64'h2);
		chk("mem_one", mem_last_addr, 64'h1000);
		op_word = 16'h003C;
		imm_size = SZQ;
		@(negedge clk);
		chk("imm_quad", ea_ext_words, 64'h4);
		imm_size = SZW;
		@(negedge clk);
		chk("imm_word", ea_ext_words, 64'h1);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		{acc_req, acc_write, acc_super, alt_is_write, probe_done} = 5'h00;
		{acc_sel, acc_wdata, probe_status, mem_addr, mem_bytes, fetch_addr, bit_num} = '0;
		{bf_base, bf_offset, bf_width, op_word, ext_word, idx_value} = '0;
		acc_size = SZW;
		imm_size = SZL;
		alt_kind = cpucrf_pkg::CPUCRF_ALT_MOVE;
		repeat (12) @(negedge clk);
		chk("reset_psw", status_word, 64'h2700);
		chk("reset_regs", {cache_ctl, bit_mask, bf_byte_count}, {32'h0, 8'h01, 3'h1});
		chk("reset_root", user_root, 64'h0);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		t_status;
		t_long;
		t_space;
		t_root;
		t_priv;
		t_probe;
		t_help;
		final_report;
	end
endmodule
